// >>> design/copt_defines.svh
// Constants for the channel offset-trim and phase-delay bank.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef COPT_DEFINES_SVH
`define COPT_DEFINES_SVH

// ==========================================================
// Sizes
`define COPT_NCH        8
`define COPT_NOFF       4
`define COPT_RES_W      18
`define COPT_NREG       12

// ==========================================================
// Register indices; byte address is four times the index
`define COPT_IDX_CH5_OFF 8'h15
`define COPT_IDX_CH6_OFF 8'h16
`define COPT_IDX_CH7_OFF 8'h17
`define COPT_IDX_CH8_OFF 8'h18
`define COPT_IDX_CH1_PH  8'h19
`define COPT_IDX_CH2_PH  8'h1A
`define COPT_IDX_CH3_PH  8'h1B
`define COPT_IDX_CH4_PH  8'h1C
`define COPT_IDX_CH5_PH  8'h1D
`define COPT_IDX_CH6_PH  8'h1E
`define COPT_IDX_CH7_PH  8'h1F
`define COPT_IDX_CH8_PH  8'h20

// ==========================================================
// Reset values and field meaning
`define COPT_OFF_RST    8'h80
`define COPT_PH_RST     8'h00
`define COPT_OFF_SHIFT  2

// ==========================================================
// Timing
`define COPT_CLK_NS     10
`define COPT_US_NS      1000
`define COPT_US_CYC     ((`COPT_US_NS + `COPT_CLK_NS - 1) / `COPT_CLK_NS)

// ==========================================================
// Bus encodings
`define COPT_HTRANS_NSEQ 2'h2
`define COPT_HTRANS_SEQ  2'h3

`endif

// >>> design/copt_pkg.sv
// Types for the channel offset-trim and phase-delay bank.
// Assumes copt_defines.svh is on the include path.
`include "copt_defines.svh"

package copt_pkg;

	// ==========================================================
	// Bus carriers
	typedef struct packed
	{
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} copt_ahb_req_type;

	typedef struct packed
	{
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} copt_ahb_rsp_type;

	// ==========================================================
	// Conversion results, one word per channel
	typedef struct packed
	{
		logic                                      valid;
		logic [`COPT_NCH-1:0][`COPT_RES_W-1:0] data;
	} copt_res_type;

	typedef enum logic [1:0]
	{
		COPT_ST_IDLE = 2'b01,
		COPT_ST_RUN  = 2'b10
	} copt_state_type;

	// ==========================================================
	// Whole module state
	typedef struct packed
	{
		logic [`COPT_NOFF-1:0][7:0] trim;
		logic [`COPT_NCH-1:0][7:0]  phase;
		logic                        dp_wr;
		logic [`COPT_NREG-1:0]       dp_sel;
		copt_ahb_rsp_type            rsp;
		copt_state_type              state;
		logic                        busy;
		logic [6:0]                  presc;
		logic [7:0]                  elapsed;
		logic [`COPT_NCH-1:0]        fired;
		logic [`COPT_NCH-1:0]        strobe;
		copt_res_type                corr;
	} copt_regs_type;

endpackage

// >>> design/copt_top.sv
// Offset-trim (channels 5..8) and per-channel phase-delay register bank with the logic
// that applies them: offset correction of results and delayed sampling.
// Assumes a single 100 MHz clock, an AHB-Lite master with one slave,
// and result words that are two's complement, one per channel.
//
// The implementer's own choice: the AHB-Lite register port.

`include "copt_defines.svh"

module copt_top
(
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire copt_pkg::copt_ahb_req_type ahb_req,
	output logic                  ahb_hrdata_unused_n,
	output copt_pkg::copt_ahb_rsp_type      ahb_rsp,
	input  wire logic             sample_start,
	output logic [7:0]            chan_sample,
	output logic                  delay_busy,
	input  wire copt_pkg::copt_res_type     raw_res,
	output copt_pkg::copt_res_type          corr_res
);
	import copt_pkg::*;

	// ==========================================================
	// Decode
	// One-hot select: bits 3..0 trim of channels 8..5,
	// bits 11..4 phase of channels 8..1.
	function automatic logic [`COPT_NREG-1:0] reg_decode(input logic [7:0] idx);
		logic [`COPT_NREG-1:0] sel;
		sel = '0;
		case (idx)
			`COPT_IDX_CH5_OFF: sel[0] = 1'b1;
			`COPT_IDX_CH6_OFF: sel[1] = 1'b1;
			`COPT_IDX_CH7_OFF: sel[2] = 1'b1;
			`COPT_IDX_CH8_OFF: sel[3] = 1'b1;
			`COPT_IDX_CH1_PH:  sel[4] = 1'b1;
			`COPT_IDX_CH2_PH:  sel[5] = 1'b1;
			`COPT_IDX_CH3_PH:  sel[6] = 1'b1;
			`COPT_IDX_CH4_PH:  sel[7] = 1'b1;
			`COPT_IDX_CH5_PH:  sel[8] = 1'b1;
			`COPT_IDX_CH6_PH:  sel[9] = 1'b1;
			`COPT_IDX_CH7_PH:  sel[10] = 1'b1;
			`COPT_IDX_CH8_PH:  sel[11] = 1'b1;
			default:           sel = '0;
		endcase
		return sel;
	endfunction

	localparam logic [6:0] US_LAST = 7'(`COPT_US_CYC - 1);
	localparam int         MAXV    = (1 << (`COPT_RES_W - 1)) - 1;

	copt_regs_type s_reg;
	copt_regs_type s_next;

	// ==========================================================
	// Offset correction per channel
	// Channels 1..4 have their trim elsewhere; here they see no correction.
	logic [`COPT_NCH-1:0][`COPT_RES_W-1:0] fixed;

	genvar gi;
	generate
		for (gi = 0; gi < `COPT_NCH; gi++)
		begin : g_corr
			logic [7:0]              code;
			logic signed [9:0]       delta;
			logic signed [`COPT_RES_W:0] sum;
			if (gi >= `COPT_NCH - `COPT_NOFF)
			begin : g_trim
				assign code = s_reg.trim[gi - (`COPT_NCH - `COPT_NOFF)];
			end
			else
			begin : g_none
				assign code = `COPT_OFF_RST;
			end
			// Offset binary: flipping the top bit gives two's complement
			assign delta = 10'(signed'(code ^ `COPT_OFF_RST)) <<< `COPT_OFF_SHIFT;
			assign sum   = signed'({raw_res.data[gi][`COPT_RES_W-1], raw_res.data[gi]})
				+ (`COPT_RES_W + 1)'(delta);
			// Saturate rather than wrap near full scale
			assign fixed[gi] = (sum > (`COPT_RES_W + 1)'(MAXV)) ? `COPT_RES_W'(MAXV) :
				(sum < -(`COPT_RES_W + 1)'(MAXV + 1)) ? `COPT_RES_W'(-(MAXV + 1)) :
				sum[`COPT_RES_W-1:0];
		end
	endgenerate

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [`COPT_NREG-1:0] ap_sel;
		logic                  ap_take;
		logic [31:0]           rdata;
		s_next = s_reg;
		ap_sel = '0;
		ap_take = 1'b0;
		rdata = '0;

		// Data phase of a write: store the low byte
		if (s_reg.dp_wr)
		begin
			for (int i = 0; i < `COPT_NOFF; i++)
			begin
				if (s_reg.dp_sel[i])
				begin
					s_next.trim[i] = ahb_req.hwdata[7:0];
				end
			end
			for (int i = 0; i < `COPT_NCH; i++)
			begin
				if (s_reg.dp_sel[`COPT_NOFF + i])
				begin
					s_next.phase[i] = ahb_req.hwdata[7:0];
				end
			end
		end

		// Address phase
		ap_take = ahb_req.hsel && ahb_req.hready
			&& (ahb_req.htrans == `COPT_HTRANS_NSEQ || ahb_req.htrans == `COPT_HTRANS_SEQ);
		if (ap_take)
		begin
			ap_sel = reg_decode(ahb_req.haddr[9:2]);
			if (ahb_req.haddr[31:10] != '0)
			begin
				ap_sel = '0;
			end
		end
		s_next.dp_wr  = ap_take && ahb_req.hwrite;
		s_next.dp_sel = ap_sel;

		// Read data built from the updated copy, so a read right after
		// a write to the same register returns the new value
		for (int i = 0; i < `COPT_NOFF; i++)
		begin
			if (ap_sel[i])
			begin
				rdata[7:0] = s_next.trim[i];
			end
		end
		for (int i = 0; i < `COPT_NCH; i++)
		begin
			if (ap_sel[`COPT_NOFF + i])
			begin
				rdata[7:0] = s_next.phase[i];
			end
		end
		if (ap_take && !ahb_req.hwrite)
		begin
			s_next.rsp.hrdata = rdata;
		end
		s_next.rsp.hreadyout = 1'b1;
		s_next.rsp.hresp     = 1'b0;

		// Phase-delay sequencer
		s_next.strobe = '0;
		case (s_reg.state)
			COPT_ST_IDLE:
			begin
				if (sample_start)
				begin
					s_next.state   = COPT_ST_RUN;
					s_next.busy    = 1'b1;
					s_next.presc   = '0;
					s_next.elapsed = '0;
					s_next.fired   = '0;
				end
			end
			COPT_ST_RUN:
			begin
				if (s_reg.presc == '0)
				begin
					for (int i = 0; i < `COPT_NCH; i++)
					begin
						// At or past: a delay lowered mid-run still fires
						if (!s_reg.fired[i] && s_reg.elapsed >= s_reg.phase[i])
						begin
							s_next.strobe[i] = 1'b1;
							s_next.fired[i]  = 1'b1;
						end
					end
				end
				if (s_reg.presc == US_LAST)
				begin
					s_next.presc   = '0;
					s_next.elapsed = s_reg.elapsed + 8'h01;
				end
				else
				begin
					s_next.presc = s_reg.presc + 7'h01;
				end
				if (&s_next.fired)
				begin
					s_next.state = COPT_ST_IDLE;
					s_next.busy  = 1'b0;
				end
			end
			default:
			begin
				s_next.state = COPT_ST_IDLE;
				s_next.busy  = 1'b0;
			end
		endcase

		// Corrected results, one cycle behind the raw ones
		s_next.corr.valid = raw_res.valid;
		if (raw_res.valid)
		begin
			s_next.corr.data = fixed;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_reg                <= '0;
			s_reg.trim           <= {`COPT_NOFF{`COPT_OFF_RST}};
			s_reg.phase          <= {`COPT_NCH{`COPT_PH_RST}};
			s_reg.rsp.hreadyout  <= 1'b1;
			s_reg.state          <= COPT_ST_IDLE;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs
	assign ahb_rsp             = s_reg.rsp;
	assign chan_sample         = s_reg.strobe;
	assign delay_busy          = s_reg.busy;
	assign corr_res            = s_reg.corr;
	assign ahb_hrdata_unused_n = s_reg.rsp.hreadyout;

endmodule

// >>> verif/copt_monitor.sv
// Port-level checks for the offset-trim and phase-delay bank.
// Assumes copt_pkg is compiled first; bound into copt_top.
module copt_monitor
(
	input wire logic                       clk_sys,
	input wire logic                       rst_b,
	input wire copt_pkg::copt_ahb_req_type ahb_req,
	input wire logic                       ahb_hrdata_unused_n,
	input wire copt_pkg::copt_ahb_rsp_type ahb_rsp,
	input wire logic                       sample_start,
	input wire logic [7:0]                 chan_sample,
	input wire logic                       delay_busy,
	input wire copt_pkg::copt_res_type     raw_res,
	input wire copt_pkg::copt_res_type     corr_res
);
	import copt_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// ==========
	// Bus
	a_rsp_okay: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp) else $error("wait or error");
	a_rd_width: assert property (ahb_rsp.hrdata[31:8] == 24'h0) else $error("wide read");
	a_ready_copy: assert property (ahb_hrdata_unused_n == ahb_rsp.hreadyout) else $error("ready copy differs");
	// ==========
	// Delayed sampling
	a_busy_start: assert property (sample_start && !delay_busy |=> delay_busy) else $error("no start");
	a_busy_end: assert property ($fell(delay_busy) |-> chan_sample != 8'h0) else $error("early end");
	a_pulse_busy: assert property (chan_sample != 8'h0 |-> $past(delay_busy)) else $error("stray pulse");
	// ==========
	// Results
	a_corr_valid: assert property (raw_res.valid |=> corr_res.valid) else $error("no result");
	a_corr_pass: assert property (raw_res.valid |=> corr_res.data[3:0] == $past(raw_res.data[3:0]))
		else $error("ch1-4 changed");
	a_corr_hold: assert property (!raw_res.valid |=> !corr_res.valid && $stable(corr_res.data))
		else $error("result moved");
	cover property ($fell(delay_busy));
	cover property (corr_res.valid);
	cover property (ahb_req.hsel && ahb_req.hwrite);
endmodule

bind copt_top copt_monitor i_mon (.clk_sys, .rst_b, .ahb_req, .ahb_hrdata_unused_n, .ahb_rsp,
	.sample_start, .chan_sample, .delay_busy, .raw_res, .corr_res);

// >>> verif/tb_top.sv
// Self-checking bench for the offset-trim and phase-delay bank.
// Assumes design package and top compiled first; no wait states.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import copt_pkg::*;
	logic             clk_sys = 1'b0;
	logic             rst_b = 1'b0;
	logic             sample_start = 1'b0;
	copt_ahb_req_type m = '0;
	copt_ahb_rsp_type rsp;
	copt_res_type     raw = '0;
	copt_res_type     corr;
	logic [7:0]       chan_sample;
	logic             delay_busy;
	logic [31:0]      rd;
	int               n_fail = 0;
	int               checked = 0;
	int               t[8];
	int               np[8];
	// Rows from index 0x15: value written; reset is 0x80 for trims
	logic [7:0]       wv[12] = '{8'h00, 8'hFF, 8'h81, 8'h80, 8'h00, 8'h01, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 8'hFF};
	int               off[8] = '{0, 0, 0, 0, -512, 508, 4, 0};
	logic [17:0]      v[3] = '{18'h00010, 18'h1FFFF, 18'h20000};

	always #5 clk_sys = ~clk_sys;

	// Bus hready comes straight from the slave
	copt_top i_dut
	(
		.clk_sys            (clk_sys),
		.rst_b              (rst_b),
		.ahb_req            ({m[71:1], rsp.hreadyout}),
		.ahb_hrdata_unused_n(),
		.ahb_rsp            (rsp),
		.sample_start       (sample_start),
		.chan_sample        (chan_sample),
		.delay_busy         (delay_busy),
		.raw_res            (raw),
		.corr_res           (corr)
	);

	// ==========
	// Helpers
	function automatic logic [17:0] sat(int x);
		return (x > 131071) ? 18'h1FFFF : (x < -131072) ? 18'h20000 : 18'(x);
	endfunction

	task automatic chk(logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task automatic xfer(logic w, logic [7:0] idx, logic [31:0] wd, output logic [31:0] q);
		m.hsel <= 1'b1;
		m.haddr <= {22'h0, idx, 2'b00};
		m.htrans <= 2'h2;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
		m.htrans <= 2'h0;
		m.hwdata <= wd;
		do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
		q = rsp.hrdata;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========
	// Tests
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 12; i++)
		begin
			xfer(1'b0, 8'(8'h15 + i), 32'h0, rd);
			chk(rd, (i < 4) ? 32'h80 : 32'h0);
			xfer(1'b1, 8'(8'h15 + i), {24'hA5A5A5, wv[i]}, rd);
			xfer(1'b0, 8'(8'h15 + i), 32'h0, rd);
			chk(rd, {24'h0, wv[i]});
		end
		xfer(1'b1, 8'h21, 32'h55, rd);
		xfer(1'b0, 8'h21, 32'h0, rd);
		chk(rd, 32'h0);
		for (int j = 0; j < 3; j++)
		begin
			raw.valid <= 1'b1;
			raw.data <= {8{v[j]}};
			@(posedge clk_sys);
			raw.valid <= 1'b0;
			@(posedge clk_sys);
			chk(32'(corr.valid), 32'h1);
			for (int c = 0; c < 8; c++)
				chk(32'(corr.data[c]), 32'(sat($signed(v[j]) + off[c])));
		end
		// Second start at k 50 lands while busy and must be ignored
		sample_start <= 1'b1;
		@(posedge clk_sys);
		for (int k = 1; k < 25600; k++)
		begin
			@(posedge clk_sys);
			sample_start <= (k == 50);
			for (int c = 0; c < 8; c++)
				if (chan_sample[c] === 1'b1)
				begin
					t[c] = k;
					np[c]++;
				end
		end
		for (int c = 0; c < 8; c++)
		begin
			chk(32'(t[c]), 32'(2 + 100 * wv[c + 4]));
			chk(32'(np[c]), 32'h1);
		end
		chk(32'(delay_busy), 32'h0);
		rst_b <= 1'b0;
		@(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		// Trims were left at 00, FF, 81, 80: only a real reset brings all back
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b0, 8'(8'h15 + i), 32'h0, rd);
			chk(rd, 32'h80);
		end
		sample_start <= 1'b1;
		@(posedge clk_sys);
		sample_start <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(32'(chan_sample), 32'hFF);
		final_report;
	end

	initial
	begin
		#1000000;
		n_fail++;
		final_report;
	end
endmodule
